// [rtl/sad_pkg.sv]
// Shared constants, commands and carriers for the subtract datapath
package sad_pkg;

  localparam int SAD_DATA_W = 8;
  localparam int SAD_NIB_W = 4;
  localparam int SAD_ADDR_W = 8;
  localparam int SAD_MEM_DEPTH = 64;

  localparam logic [SAD_DATA_W-1:0] SAD_WORK_RST = 8'h00;
  localparam logic [SAD_DATA_W-1:0] SAD_ZERO = 8'h00;
  localparam logic [SAD_DATA_W-1:0] SAD_RDATA_RST = 8'h00;

  // Carry polarity: carry is the inverse of borrow
  localparam logic SAD_CARRY_ON_BORROW = 1'b0;
  localparam logic SAD_CARRY_NO_BORROW = 1'b1;

  typedef enum logic [2:0] {
    SAD_OP_NOP,
    SAD_OP_SUB_WORK,
    SAD_OP_SUB_MEM,
    SAD_OP_LOAD_MEM,
    SAD_OP_LOAD_WORK,
    SAD_OP_READ_MEM
  } sad_op_e;

  typedef struct packed {
    logic valid;
    sad_op_e op;
    logic [SAD_ADDR_W-1:0] addr;
    logic [SAD_DATA_W-1:0] data;
  } sad_cmd_s;

  typedef struct packed {
    logic signed_range_flag;
    logic zero_flag;
    logic half_borrow_flag;
    logic carry_flag;
  } sad_flags_s;

  localparam sad_flags_s SAD_FLAGS_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic [SAD_DATA_W-1:0] diff;
    sad_flags_s flags;
  } sad_result_s;

endpackage

// [rtl/sad_data_mem.sv]
// Small data memory with registered read data
`timescale 1ns/1ps
module sad_data_mem
  import sad_pkg::*;
#(
  parameter int WIDTH = SAD_DATA_W,
  parameter int DEPTH = SAD_MEM_DEPTH
)
(
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_wr_en,
  input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // The address bits must reach every word and nothing past the array
  if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_param_check
    $error("sad_data_mem parameters out of range");
  end

  // No reset on the array so it can map onto block memory
  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
    begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem_q[i_rd_addr];
  end

endmodule

// [rtl/sad_datapath.sv]
// Subtract datapath with work register, status flags and data memory
`timescale 1ns/1ps
module sad_datapath
  import sad_pkg::*;
#(
  parameter int MEM_DEPTH = SAD_MEM_DEPTH
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Command from the decoder
  input wire sad_cmd_s i_cmd,
  output logic o_ready,
  // Results
  output logic o_done,
  output logic [SAD_DATA_W-1:0] o_work_register,
  output sad_flags_s o_flags,
  output logic [SAD_DATA_W-1:0] o_rdata
);

  localparam int MA_W = $clog2(MEM_DEPTH);

  // The address field is fixed; a deeper memory would lose addresses
  // An uneven depth would leave address codes pointing past the array
  if (MEM_DEPTH < 2 || MEM_DEPTH > (1 << SAD_ADDR_W) || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("MEM_DEPTH out of range");
  end

  typedef enum logic {
    SAD_ST_IDLE,
    SAD_ST_EXEC
  } sad_state_e;

  // Subtract a minus m with flags
  function automatic sad_result_s sad_subtract(
    input logic [SAD_DATA_W-1:0] a,
    input logic [SAD_DATA_W-1:0] m
  );
    logic [SAD_DATA_W:0] full;
    logic [SAD_NIB_W:0] nib;
    sad_result_s r;
    full = {1'b0, a} - {1'b0, m};
    nib = {1'b0, a[SAD_NIB_W-1:0]} - {1'b0, m[SAD_NIB_W-1:0]};
    r.diff = full[SAD_DATA_W-1:0];
    r.flags.carry_flag = full[SAD_DATA_W] ? SAD_CARRY_ON_BORROW : SAD_CARRY_NO_BORROW;
    r.flags.half_borrow_flag = ~nib[SAD_NIB_W];
    r.flags.zero_flag = (full[SAD_DATA_W-1:0] == SAD_ZERO);
    r.flags.signed_range_flag = (a[SAD_DATA_W-1] ^ m[SAD_DATA_W-1])
      & (a[SAD_DATA_W-1] ^ full[SAD_DATA_W-1]);
    return r;
  endfunction

  // True while the executing command carries the wanted operation
  function automatic logic sad_exec_is(
    input logic exec,
    input sad_op_e have,
    input sad_op_e want
  );
    return exec & (have == want);
  endfunction

  sad_state_e state_q;
  sad_state_e state_d;
  sad_cmd_s cmd_q;
  logic [SAD_DATA_W-1:0] work_q;
  logic [SAD_DATA_W-1:0] work_d;
  sad_flags_s flags_q;
  sad_flags_s flags_d;
  logic ready_q;
  logic done_q;
  logic [SAD_DATA_W-1:0] rdata_q;
  logic [SAD_DATA_W-1:0] rdata_d;
  logic [SAD_DATA_W-1:0] mem_rd_data;

  // Decode of the accepted and the executing command
  wire take = i_cmd.valid & ready_q;
  wire in_exec = (state_q == SAD_ST_EXEC);
  wire op_sub_work = sad_exec_is(in_exec, cmd_q.op, SAD_OP_SUB_WORK);
  wire op_sub_mem = sad_exec_is(in_exec, cmd_q.op, SAD_OP_SUB_MEM);
  wire op_load_mem = sad_exec_is(in_exec, cmd_q.op, SAD_OP_LOAD_MEM);
  wire op_load_work = sad_exec_is(in_exec, cmd_q.op, SAD_OP_LOAD_WORK);
  wire op_read_mem = sad_exec_is(in_exec, cmd_q.op, SAD_OP_READ_MEM);
  wire any_sub = op_sub_work | op_sub_mem;

  wire sad_result_s sub_res = sad_subtract(work_q, mem_rd_data);

  // Memory write selection: only the memory-target subtract and the memory load write
  wire mem_wr_en = op_sub_mem | op_load_mem;
  wire [SAD_DATA_W-1:0] mem_wr_data = op_sub_mem ? sub_res.diff : cmd_q.data;
  wire [MA_W-1:0] mem_wr_addr = cmd_q.addr[MA_W-1:0];
  wire [MA_W-1:0] mem_rd_addr = i_cmd.addr[MA_W-1:0];

  // Work register: written by the accumulator-target subtract or the work load
  assign work_d = op_sub_work ? sub_res.diff :
    (op_load_work ? cmd_q.data : work_q);
  assign flags_d = any_sub ? sub_res.flags : flags_q;
  assign rdata_d = op_read_mem ? mem_rd_data : rdata_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SAD_ST_IDLE:
      begin
        if (take)
        begin
          state_d = SAD_ST_EXEC;
        end
      end
      SAD_ST_EXEC:
      begin
        state_d = SAD_ST_IDLE;
      end
      default:
      begin
        state_d = SAD_ST_IDLE;
      end
    endcase
  end

  // Read data arrive one cycle after the address, hence the exec state
  sad_data_mem #(
    .WIDTH(SAD_DATA_W),
    .DEPTH(MEM_DEPTH)
  ) u_mem (
    .i_clk(i_clk),
    .i_wr_en(mem_wr_en),
    .i_wr_addr(mem_wr_addr),
    .i_wr_data(mem_wr_data),
    .i_rd_addr(mem_rd_addr),
    .o_rd_data(mem_rd_data)
  );

  // Sequencer state
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= SAD_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Command latch, held through execute so the decoder may move on
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cmd_q <= '0;
    end
    else if (take)
    begin
      cmd_q <= i_cmd;
    end
  end

  // Ready from the next state, so the output still leaves a flip-flop
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ready_q <= 1'b1;
    end
    else
    begin
      ready_q <= (state_d == SAD_ST_IDLE);
    end
  end

  // Done pulses for the one cycle after execute
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= in_exec;
    end
  end

  // Work register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      work_q <= SAD_WORK_RST;
    end
    else
    begin
      work_q <= work_d;
    end
  end

  // Status flags
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      flags_q <= SAD_FLAGS_RST;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // Read data hold until the next memory read
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rdata_q <= SAD_RDATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign o_ready = ready_q;
  assign o_done = done_q;
  assign o_work_register = work_q;
  assign o_flags = flags_q;
  assign o_rdata = rdata_q;

endmodule

// [verif/sad_datapath_monitor.sv]
// Port checker for the subtract datapath
`timescale 1ns/1ps
module sad_datapath_monitor
  import sad_pkg::*;
(
  // Clock, reset and command
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sad_cmd_s i_cmd,
  // Results
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic [SAD_DATA_W-1:0] o_work_register,
  input wire sad_flags_s o_flags
);
  logic [SAD_DATA_W-1:0] w1_q;
  logic [SAD_DATA_W-1:0] w2_q;
  wire sw = i_cmd.valid && o_ready && i_cmd.op == SAD_OP_SUB_WORK;
  wire sm = i_cmd.valid && o_ready && i_cmd.op == SAD_OP_SUB_MEM;
  // Memory is hidden, so its operand is recovered from old minus new work value
  wire [SAD_DATA_W-1:0] m_w = w2_q - o_work_register;
  wire ov_w = (w2_q[7] ^ m_w[7]) & (w2_q[7] ^ o_work_register[7]);
  always_ff @(posedge i_clk)
  begin
    w1_q <= o_work_register;
    w2_q <= w1_q;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_work; sw |-> ##1 !o_ready ##1 o_done && o_ready; endproperty
  a_work: assert property (p_work) else $error("subtract late");
  property p_brw; sw ##2 w2_q < m_w |-> o_flags.carry_flag == SAD_CARRY_ON_BORROW; endproperty
  a_brw: assert property (p_brw) else $error("carry set on borrow");
  property p_nbrw; sw ##2 w2_q >= m_w |-> o_flags.carry_flag == SAD_CARRY_NO_BORROW; endproperty
  a_nbrw: assert property (p_nbrw) else $error("carry clear");
  property p_mem; sm |-> ##2 o_done && o_work_register == w2_q; endproperty
  a_mem: assert property (p_mem) else $error("work changed");
  property p_flg;
    sw |-> ##2 o_flags.zero_flag == (o_work_register == SAD_ZERO) &&
      o_flags.half_borrow_flag == (w2_q[3:0] >= m_w[3:0]) && o_flags.signed_range_flag == ov_w;
  endproperty
  a_flg: assert property (p_flg) else $error("flags wrong");
  c_work: cover property (sw);
  c_mem: cover property (sm);
  c_brw: cover property (sw ##2 w2_q < m_w);
endmodule
bind sad_datapath sad_datapath_monitor i_mon (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(i_cmd),
  .o_ready(o_ready), .o_done(o_done), .o_work_register(o_work_register), .o_flags(o_flags));

// [verif/testbench.sv]
// Self-checking bench for the subtract datapath
`timescale 1ns/1ps
module testbench;
  import sad_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  sad_cmd_s i_cmd = '0;
  logic o_ready;
  logic o_done;
  logic [7:0] o_work_register;
  logic [7:0] o_rdata;
  sad_flags_s o_flags;
  int failures = 0;
  int total_checks = 0;
  logic [7:0] pa [6] = '{8'h05, 8'h07, 8'h05, 8'h80, 8'h7f, 8'h10};
  logic [7:0] pm [6] = '{8'h07, 8'h05, 8'h05, 8'h01, 8'hff, 8'h01};
  always #5 i_clk = ~i_clk;
  sad_datapath i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(i_cmd), .o_ready(o_ready), .o_done(o_done),
    .o_work_register(o_work_register), .o_flags(o_flags), .o_rdata(o_rdata));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] flags_of(input logic [7:0] a, input logic [7:0] m);
    logic [7:0] d;
    int s;
    d = a - m;
    s = $signed(a) - $signed(m);
    return {4'h0, ((s < -128) || (s > 127)), d == 8'h00, a[3:0] >= m[3:0], a >= m};
  endfunction
  task automatic run(input sad_op_e op, input logic [7:0] addr, input logic [7:0] data);
    int n;
    @(negedge i_clk);
    chk({7'h00, o_ready}, 8'h01);
    i_cmd <= '{1'b1, op, addr, data};
    @(negedge i_clk);
    i_cmd.valid <= 1'b0;
    chk({6'h00, o_ready, o_done}, 8'h00);
    for (n = 0; n < 4 && o_done !== 1'b1; n++)
      @(negedge i_clk);
    chk({6'h00, o_ready, o_done}, 8'h03);
    chk(n[7:0], 8'h01);
  endtask
  task automatic reset_case();
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    chk(o_work_register, SAD_WORK_RST);
    chk({4'h0, o_flags}, {4'h0, SAD_FLAGS_RST});
    chk(o_rdata, SAD_RDATA_RST);
    chk({6'h00, o_ready, o_done}, 8'h02);
  endtask
  task automatic refused_case();
    run(SAD_OP_LOAD_MEM, 8'h05, 8'h01);
    run(SAD_OP_LOAD_WORK, 8'h00, 8'h3c);
    @(negedge i_clk);
    i_cmd <= '{1'b1, SAD_OP_SUB_WORK, 8'h05, 8'h00};
    @(negedge i_clk);
    // A load offered while busy must be dropped, not queued
    i_cmd <= '{1'b1, SAD_OP_LOAD_WORK, 8'h00, 8'h99};
    @(negedge i_clk);
    i_cmd.valid <= 1'b0;
    chk({6'h00, o_ready, o_done}, 8'h03);
    chk(o_work_register, 8'h3b);
    @(negedge i_clk);
    chk({6'h00, o_ready, o_done}, 8'h02);
    chk(o_work_register, 8'h3b);
    run(SAD_OP_NOP, 8'h05, 8'h00);
    chk(o_work_register, 8'h3b);
    chk({4'h0, o_flags}, flags_of(8'h3c, 8'h01));
  endtask
  task automatic sub_work_case(input logic [7:0] a, input logic [7:0] m);
    run(SAD_OP_LOAD_MEM, 8'h03, m);
    run(SAD_OP_LOAD_WORK, 8'h00, a);
    run(SAD_OP_SUB_WORK, 8'h03, 8'h00);
    chk(o_work_register, a - m);
    chk({4'h0, o_flags}, flags_of(a, m));
    run(SAD_OP_READ_MEM, 8'h03, 8'h00);
    chk(o_rdata, m);
  endtask
  task automatic sub_mem_case(input logic [7:0] a, input logic [7:0] m);
    run(SAD_OP_LOAD_MEM, 8'h2a, m);
    run(SAD_OP_LOAD_WORK, 8'h00, a);
    run(SAD_OP_SUB_MEM, 8'h2a, 8'h00);
    chk(o_work_register, a);
    chk({4'h0, o_flags}, flags_of(a, m));
    run(SAD_OP_READ_MEM, 8'h2a, 8'h00);
    chk(o_rdata, a - m);
  endtask
  initial
  begin
    reset_case();
    for (int k = 0; k < 6; k++)
    begin
      sub_work_case(pa[k], pm[k]);
      sub_mem_case(pa[k], pm[k]);
    end
    refused_case();
    reset_case();
    give_verdict();
  end
  // Roughly ten times the expected run, so a stuck handshake cannot hang
  initial
  begin
    #20000;
    failures++;
    give_verdict();
  end
endmodule
